// ### mptb_pkg.sv
// package for the motor pwm time base: register offsets, field positions,
// reset values and mode codes. assumes a 32-bit classic wishbone slave.
`default_nettype none
package mptb_pkg;
   // register byte offsets, one aligned word each
   localparam logic [3:0] MPTB_OFS_CONTROL = 4'h0;
   localparam logic [3:0] MPTB_OFS_COUNT   = 4'h4;
   localparam logic [3:0] MPTB_OFS_PERIOD  = 4'h8;
   localparam logic [3:0] MPTB_OFS_COMPARE = 4'hC;
   localparam logic [3:0] MPTB_OFS_DUTY    = 4'h0;
   // control field positions
   localparam int MPTB_BIT_ENABLE    = 15;
   localparam int MPTB_BIT_IDLE_STOP = 13;
   localparam int MPTB_POS_POSTSCALE = 4;
   localparam int MPTB_POS_PRESCALE  = 2;
   localparam int MPTB_POS_MODE      = 0;
   localparam int MPTB_BIT_DIR       = 15;
   // writable bits of control; bits 14 and 12..8 stay zero
   localparam logic [15:0] MPTB_CONTROL_MASK = 16'hA0FF;
   localparam logic [15:0] MPTB_RESET_VALUE  = 16'h0000;
   // prescale divide counts minus one for codes 00..11
   localparam logic [5:0] MPTB_PRE_1  = 6'h00;
   localparam logic [5:0] MPTB_PRE_4  = 6'h03;
   localparam logic [5:0] MPTB_PRE_16 = 6'h0F;
   localparam logic [5:0] MPTB_PRE_64 = 6'h3F;
   typedef enum logic [1:0] {
      MPTB_FREE_RUN   = 2'b00,
      MPTB_SINGLE     = 2'b01,
      MPTB_UPDOWN     = 2'b10,
      MPTB_UPDOWN_DBL = 2'b11
   } mptb_mode_t;
endpackage
`default_nettype wire

// ### mptb_time_base.sv
// motor pwm time base, special event comparator and duty pairs.
// assumes a classic wishbone master on clk_i and a synchronous idle input.
//
// Behaviour
// - two instances exist: six-channel (PAIRS=3) and two-channel (PAIRS=1).
// - large instance has three duty generators, each driving a high/low pair.
// - in complementary mode the low output is the inverse of the high output.
// - small instance has one duty generator and one output pair.
// - counter runs only while the enable bit 15 of control is one.
// - idle-stop bit set halts the time base while the cpu idles.
// - four-bit postscale divides the period event by field plus one.
// - prescale codes 00,01,10,11 give 1,4,16,64 instruction cycles per count.
// - mode 00 is a free-running counter.
// - mode 01 generates a single period then stops.
// - mode 10 counts up then down continuously, center aligned.
// - mode 11 is up/down with an event at both turning points.
// - count register bit 15 is read-only direction, one when counting down.
// - count value is readable and writable in bits 14..0.
// - period holds 15 bits; bit 15 reads zero.
// - trigger fires when count bits 14..0 equal the compare value.
// - compare bit 15 selects trigger direction: one down, zero up.
// - unimplemented control bits ignore writes and read zero.
// - all implemented bits clear to zero on reset.
//
// Added by the designer: the register offsets and the Wishbone register port.
`timescale 1ns/10ps
`default_nettype none
module mptb_time_base
   import mptb_pkg::*;
#(
   parameter int PAIRS = 3
) (
   input  wire logic              clk_i,
   input  wire logic              rst_i,
   input  wire logic              cpu_idle_i,
   input  wire logic              wb_cyc_i,
   input  wire logic              wb_stb_i,
   input  wire logic              wb_we_i,
   input  wire logic [4:0]        wb_adr_i,
   input  wire logic [3:0]        wb_sel_i,
   input  wire logic [31:0]       wb_dat_i,
   output logic      [31:0]       wb_dat_o,
   output logic                   wb_ack_o,
   input  wire logic [PAIRS-1:0]  pair_independent_i,
   output logic      [PAIRS-1:0]  high_o,
   output logic      [PAIRS-1:0]  low_o,
   output logic                   special_trigger_o,
   output logic                   period_event_o,
   output logic                   turn_event_o
);
   import mptb_pkg::*;

   typedef struct packed {
      logic [15:0]            control;
      logic [14:0]            count;
      logic                   dir;
      logic [14:0]            period;
      logic [15:0]            compare;
      logic [PAIRS-1:0][14:0] duty;
      logic [5:0]             pre_cnt;
      logic [3:0]             post_cnt;
      logic                   ack;
      logic [31:0]            rdata;
      logic                   trig;
      logic                   pevt;
      logic                   tevt;
      logic [PAIRS-1:0]       high;
      logic                   idle_s1;
      logic                   idle_s2;
   } mptb_state_t;

   mptb_state_t s_q;
   mptb_state_t s_d;

   // byte-lane merge of a 16-bit register
   function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                           input logic [15:0] new_v,
                                           input logic [1:0]  sel);
      merge16 = {sel[1] ? new_v[15:8] : old_v[15:8], sel[0] ? new_v[7:0] : old_v[7:0]};
   endfunction

   // prescale code to terminal count
   function automatic logic [5:0] pre_limit(input logic [1:0] code);
      case (code)
         2'b00:   pre_limit = MPTB_PRE_1;
         2'b01:   pre_limit = MPTB_PRE_4;
         2'b10:   pre_limit = MPTB_PRE_16;
         default: pre_limit = MPTB_PRE_64;
      endcase
   endfunction

   logic       bus_req;
   logic       wr_en;
   logic [4:0] reg_sel;
   logic       tick;
   logic       running;
   logic       period_hit;
   logic       zero_hit;
   mptb_mode_t mode;
   logic [15:0] wr_word;

   assign bus_req = wb_cyc_i && wb_stb_i && !s_q.ack;
   // writes land on the edge where the master sees ack, not the taking edge
   assign wr_en   = wb_cyc_i && wb_stb_i && wb_we_i && s_q.ack;
   assign reg_sel = wb_adr_i;
   assign mode    = mptb_mode_t'(s_q.control[MPTB_POS_MODE +: 2]);
   // idle passes two flops since it comes from the cpu power logic
   assign running = s_q.control[MPTB_BIT_ENABLE]
                    && !(s_q.control[MPTB_BIT_IDLE_STOP] && s_q.idle_s2);
   assign tick       = running && (s_q.pre_cnt == pre_limit(s_q.control[MPTB_POS_PRESCALE +: 2]));
   assign period_hit = (s_q.count == s_q.period);
   assign zero_hit   = (s_q.count == 15'h0000);

   always_comb begin
      s_d         = s_q;
      s_d.idle_s1 = cpu_idle_i;
      s_d.idle_s2 = s_q.idle_s1;
      s_d.ack     = bus_req;
      s_d.trig    = 1'b0;
      s_d.pevt    = 1'b0;
      s_d.tevt    = 1'b0;
      wr_word     = wb_dat_i[15:0];
      // prescaler counts instruction cycles while running
      if (running) begin
         s_d.pre_cnt = tick ? 6'h00 : s_q.pre_cnt + 6'h01;
      end
      // counter motion per mode
      if (tick) begin
         case (mode)
            MPTB_FREE_RUN, MPTB_SINGLE: begin
               s_d.dir = 1'b0;
               if (period_hit) begin
                  s_d.count = 15'h0000;
                  s_d.pevt  = 1'b1;
                  if (mode == MPTB_SINGLE) begin
                     s_d.control[MPTB_BIT_ENABLE] = 1'b0;
                  end
               end else begin
                  s_d.count = s_q.count + 15'h0001;
               end
            end
            default: begin
               // up/down: turn at period and at zero
               if (!s_q.dir && period_hit) begin
                  s_d.dir   = 1'b1;
                  s_d.count = s_q.count - 15'h0001;
                  s_d.tevt  = (mode == MPTB_UPDOWN_DBL);
               end else if (s_q.dir && zero_hit) begin
                  s_d.dir   = 1'b0;
                  s_d.count = s_q.count + 15'h0001;
                  s_d.pevt  = 1'b1;
                  s_d.tevt  = 1'b1;
               end else begin
                  s_d.count = s_q.dir ? s_q.count - 15'h0001 : s_q.count + 15'h0001;
               end
            end
         endcase
         // special event trigger on value and direction
         s_d.trig = (s_q.count == s_q.compare[14:0])
                    && (s_q.dir == s_q.compare[15]);
      end
      // postscaler over period events
      if (s_d.pevt) begin
         if (s_q.post_cnt == s_q.control[MPTB_POS_POSTSCALE +: 4]) begin
            s_d.post_cnt = 4'h0;
         end else begin
            s_d.post_cnt = s_q.post_cnt + 4'h1;
            s_d.pevt     = 1'b0;
         end
      end
      // duty compare per pair, registered against count
      for (int i = 0; i < PAIRS; i++) begin
         s_d.high[i] = s_q.count < s_q.duty[i];
      end
      // bus writes take effect on the acknowledged edge; they win over counting
      if (wr_en) begin
         case (reg_sel)
            {1'b0, MPTB_OFS_CONTROL}: begin
               s_d.control = merge16(s_q.control, wr_word, wb_sel_i[1:0])
                             & MPTB_CONTROL_MASK;
            end
            {1'b0, MPTB_OFS_COUNT}: begin
               s_d.count = 15'(merge16({1'b0, s_q.count}, wr_word, wb_sel_i[1:0]));
            end
            {1'b0, MPTB_OFS_PERIOD}: begin
               s_d.period = 15'(merge16({1'b0, s_q.period}, wr_word, wb_sel_i[1:0]));
            end
            {1'b0, MPTB_OFS_COMPARE}: begin
               s_d.compare = merge16(s_q.compare, wr_word, wb_sel_i[1:0]);
            end
            default: begin
               // duty registers live from 0x10, one word per pair
               for (int i = 0; i < PAIRS; i++) begin
                  if (reg_sel == 5'(5'h10 + 4 * i)) begin
                     s_d.duty[i] = 15'(merge16({1'b0, s_q.duty[i]}, wr_word, wb_sel_i[1:0]));
                  end
               end
            end
         endcase
      end
      // read data registered with ack; unmapped reads zero
      s_d.rdata = 32'h0000_0000;
      if (bus_req && !wb_we_i) begin
         case (reg_sel)
            {1'b0, MPTB_OFS_CONTROL}: s_d.rdata = {16'h0000, s_q.control};
            {1'b0, MPTB_OFS_COUNT}:   s_d.rdata = {16'h0000, s_q.dir, s_q.count};
            {1'b0, MPTB_OFS_PERIOD}:  s_d.rdata = {17'h00000, s_q.period};
            {1'b0, MPTB_OFS_COMPARE}: s_d.rdata = {16'h0000, s_q.compare};
            default: begin
               for (int i = 0; i < PAIRS; i++) begin
                  if (reg_sel == 5'(5'h10 + 4 * i)) begin
                     s_d.rdata = {17'h00000, s_q.duty[i]};
                  end
               end
            end
         endcase
      end
   end

   // single state register; everything clears on reset
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign wb_ack_o          = s_q.ack;
   assign wb_dat_o          = s_q.rdata;
   assign special_trigger_o = s_q.trig;
   assign period_event_o    = s_q.pevt;
   assign turn_event_o      = s_q.tevt;
   assign high_o            = s_q.high;
   // low is complement unless pair set independent
   assign low_o = ~s_q.high | pair_independent_i;

   chk_single_stops: assert property (@(posedge clk_i) disable iff (rst_i)
      (tick && mode == MPTB_SINGLE && period_hit && !wr_en)
      |=> !s_q.control[MPTB_BIT_ENABLE] && s_q.count == 15'h0000)
      else $error("single pulse did not stop");
   chk_stopped_hold: assert property (@(posedge clk_i) disable iff (rst_i)
      (!s_q.control[MPTB_BIT_ENABLE] && !wr_en) |=> $stable(s_q.count))
      else $error("counter moved while disabled");
   chk_idle_halt: assert property (@(posedge clk_i) disable iff (rst_i)
      (s_q.control[MPTB_BIT_IDLE_STOP] && s_q.idle_s2) |-> !tick)
      else $error("time base ticked in idle");
   chk_free_wrap: assert property (@(posedge clk_i) disable iff (rst_i)
      (tick && mode == MPTB_FREE_RUN && period_hit && !wr_en)
      |=> s_q.count == 15'h0000)
      else $error("free run did not wrap");
   chk_turn_down: assert property (@(posedge clk_i) disable iff (rst_i)
      (tick && mode[1] && !s_q.dir && period_hit && !wr_en) |=> s_q.dir)
      else $error("up/down did not reverse at period");
   chk_trig_match: assert property (@(posedge clk_i) disable iff (rst_i)
      s_q.trig |-> $past(s_q.count) == $past(s_q.compare[14:0])
                   && $past(s_q.dir) == $past(s_q.compare[15]))
      else $error("trigger without match");
   chk_ctrl_zero: assert property (@(posedge clk_i) disable iff (rst_i)
      (s_q.control & ~MPTB_CONTROL_MASK) == 16'h0000)
      else $error("unimplemented control bit set");
   chk_low_comp: assert property (@(posedge clk_i) disable iff (rst_i)
      !pair_independent_i[0] |-> low_o[0] == !high_o[0])
      else $error("low output not complementary");
   chk_dbl_event: assert property (@(posedge clk_i) disable iff (rst_i)
      (tick && mode == MPTB_UPDOWN_DBL && !s_q.dir && period_hit && !wr_en)
      |=> turn_event_o)
      else $error("no event at top turn");
   // ack is a single-cycle pulse
   chk_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
      s_q.ack |=> !s_q.ack)
      else $error("ack held longer than one cycle");
   // every taken request is answered next cycle
   chk_ack_follows: assert property (@(posedge clk_i) disable iff (rst_i)
      bus_req |=> s_q.ack)
      else $error("request not acknowledged");
   // no prescaled tick while disabled
   chk_enable_gate: assert property (@(posedge clk_i) disable iff (rst_i)
      !s_q.control[MPTB_BIT_ENABLE] |-> !tick)
      else $error("tick while disabled");
   // direction does not move while stopped
   chk_stop_dir: assert property (@(posedge clk_i) disable iff (rst_i)
      (!s_q.control[MPTB_BIT_ENABLE] && !wr_en) |=> $stable(s_q.dir))
      else $error("direction moved while disabled");
   // count read returns direction in the top bit
   chk_dir_read: assert property (@(posedge clk_i) disable iff (rst_i)
      (bus_req && !wb_we_i && reg_sel == {1'b0, MPTB_OFS_COUNT}) |=> wb_dat_o[15] == $past(s_q.dir))
      else $error("direction bit not read back");
   // period top bit always reads zero
   chk_period_msb: assert property (@(posedge clk_i) disable iff (rst_i)
      (bus_req && !wb_we_i && reg_sel == {1'b0, MPTB_OFS_PERIOD}) |=> !wb_dat_o[15])
      else $error("period top bit read as one");
   // free and single modes step up by one
   chk_free_step: assert property (@(posedge clk_i) disable iff (rst_i)
      (tick && !mode[1] && !period_hit && !wr_en) |=> s_q.count == $past(s_q.count) + 15'h0001)
      else $error("free run did not step up");
   // counting up in up/down modes
   chk_up_step: assert property (@(posedge clk_i) disable iff (rst_i)
      (tick && mode[1] && !s_q.dir && !period_hit && !wr_en) |=> s_q.count == $past(s_q.count) + 15'h0001)
      else $error("up/down did not step up");
   // counting down in up/down modes
   chk_down_step: assert property (@(posedge clk_i) disable iff (rst_i)
      (tick && mode[1] && s_q.dir && !zero_hit && !wr_en) |=> s_q.count == $past(s_q.count) - 15'h0001)
      else $error("up/down did not step down");
   // reversal to up at zero
   chk_turn_up: assert property (@(posedge clk_i) disable iff (rst_i)
      (tick && mode[1] && s_q.dir && zero_hit && !wr_en) |=> !s_q.dir)
      else $error("up/down did not reverse at zero");
   // bottom turn raises the turn event in both up/down modes
   chk_bottom_event: assert property (@(posedge clk_i) disable iff (rst_i)
      (tick && mode[1] && s_q.dir && zero_hit && !wr_en) |=> turn_event_o)
      else $error("no event at bottom turn");
   // plain up/down has no top event; only mode 11 updates twice
   chk_up_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
      (tick && mode == MPTB_UPDOWN && !s_q.dir && period_hit && !wr_en) |=> !turn_event_o)
      else $error("top event in single-update mode");
   // edge modes never count down
   chk_free_dir: assert property (@(posedge clk_i) disable iff (rst_i)
      (tick && !mode[1] && !wr_en) |=> !s_q.dir)
      else $error("direction set in edge mode");
   // high output follows count against duty
   chk_high_duty: assert property (@(posedge clk_i) disable iff (rst_i)
      1'b1 |=> high_o[0] == ($past(s_q.count) < $past(s_q.duty[0])))
      else $error("high output does not follow duty");
   // full control write keeps only implemented bits
   chk_ctrl_write: assert property (@(posedge clk_i) disable iff (rst_i)
      (wr_en && reg_sel == {1'b0, MPTB_OFS_CONTROL} && wb_sel_i[1:0] == 2'b11)
      |=> s_q.control == ($past(wb_dat_i[15:0]) & MPTB_CONTROL_MASK))
      else $error("control write not applied");
   // software write of count wins over counting
   chk_count_write: assert property (@(posedge clk_i) disable iff (rst_i)
      (wr_en && reg_sel == {1'b0, MPTB_OFS_COUNT} && wb_sel_i[1:0] == 2'b11)
      |=> s_q.count == $past(wb_dat_i[14:0]))
      else $error("count write not applied");
   // period write keeps fifteen bits
   chk_period_write: assert property (@(posedge clk_i) disable iff (rst_i)
      (wr_en && reg_sel == {1'b0, MPTB_OFS_PERIOD} && wb_sel_i[1:0] == 2'b11)
      |=> s_q.period == $past(wb_dat_i[14:0]))
      else $error("period write not applied");
   // compare write keeps direction and value
   chk_compare_write: assert property (@(posedge clk_i) disable iff (rst_i)
      (wr_en && reg_sel == {1'b0, MPTB_OFS_COMPARE} && wb_sel_i[1:0] == 2'b11)
      |=> s_q.compare == $past(wb_dat_i[15:0]))
      else $error("compare write not applied");
   // trigger only follows a tick
   chk_no_tick_trig: assert property (@(posedge clk_i) disable iff (rst_i)
      !tick |=> !special_trigger_o)
      else $error("trigger without tick");
   // period event only follows a tick
   chk_pevt_tick: assert property (@(posedge clk_i) disable iff (rst_i)
      period_event_o |-> $past(tick))
      else $error("period event without tick");
   // turn events only in up/down modes
   chk_tevt_mode: assert property (@(posedge clk_i) disable iff (rst_i)
      turn_event_o |-> $past(mode[1]))
      else $error("turn event in edge mode");
   // idle stop freezes the count
   chk_idle_hold: assert property (@(posedge clk_i) disable iff (rst_i)
      (s_q.control[MPTB_BIT_IDLE_STOP] && s_q.idle_s2 && !wr_en) |=> $stable(s_q.count))
      else $error("count moved in idle stop");
   // last pair complementary as well
   chk_last_comp: assert property (@(posedge clk_i) disable iff (rst_i)
      !pair_independent_i[PAIRS-1] |-> low_o[PAIRS-1] == !high_o[PAIRS-1])
      else $error("last low output not complementary");
   // independent pair parks its low output high
   chk_indep_low: assert property (@(posedge clk_i) disable iff (rst_i)
      pair_independent_i[0] |-> low_o[0])
      else $error("independent low output not high");
   // unmapped word reads zero
   chk_unmapped_read: assert property (@(posedge clk_i) disable iff (rst_i)
      (PAIRS < 4 && bus_req && !wb_we_i && reg_sel == 5'h1C) |=> wb_dat_o == 32'h0000_0000)
      else $error("unmapped read not zero");
   // reset clears the whole state
   chk_reset_clear: assert property (@(posedge clk_i)
      rst_i |=> s_q == '0)
      else $error("state not cleared by reset");
endmodule
`default_nettype wire

// ### mptb_gate_model.sv
// gate driver load for the pwm pairs: counts cycles with a broken complement.
// assumes pair outputs settle before the clock edge; independent pairs skipped.
`timescale 1ns/10ps
`default_nettype none
module mptb_gate_model #(
   parameter int PAIRS = 3
) (
   input  wire logic             clk_i,
   input  wire logic             rst_i,
   input  wire logic [PAIRS-1:0] high_i,
   input  wire logic [PAIRS-1:0] low_i,
   input  wire logic [PAIRS-1:0] indep_i,
   output var  int               fault_o
);
   // both switches of a leg on together would short the supply rail
   initial fault_o = 0;
   always @(posedge clk_i) begin
      // outputs are unsettled until reset has been applied
      if (!rst_i && ((high_i ^ low_i) | indep_i) !== {PAIRS{1'b1}}) fault_o <= fault_o + 1;
   end
endmodule
`default_nettype wire

// ### mptb_time_base_tb_top.sv
// bench for the motor pwm time base: wishbone tasks, mode scenarios, gate load.
// assumes the design package, a 10 MHz clock and duty words from 0x10 upward.
`timescale 1ns/10ps
`default_nettype none
module mptb_time_base_tb_top;
   import mptb_pkg::*;
   logic        clk_i = 0, rst_i = 1, idle = 0, cyc = 0, stb = 0, we = 0;
   logic [4:0]  adr = '0;
   logic [3:0]  sel = '0;
   logic [31:0] wdat = '0, rdat;
   logic        ack, trig, pev, tev;
   logic [2:0]  indep = '0, hi, lo;
   logic        hs, ls;
   logic [15:0] q, p;
   int          err_count = 0, tests_run = 0, fault, n;
   logic [31:0] rs = 32'h0000_4D06;
   // 100 ns clock
   always #50 clk_i = ~clk_i;
   mptb_time_base #(.PAIRS(3)) DUT (.clk_i(clk_i), .rst_i(rst_i), .cpu_idle_i(idle),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
      .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .pair_independent_i(indep),
      .high_o(hi), .low_o(lo), .special_trigger_o(trig), .period_event_o(pev),
      .turn_event_o(tev));
   // two-channel instance on the same bus; only its pair is watched
   mptb_time_base #(.PAIRS(1)) small_dut (.clk_i(clk_i), .rst_i(rst_i), .cpu_idle_i(idle),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
      .wb_dat_i(wdat), .wb_dat_o(), .wb_ack_o(), .pair_independent_i(1'b0),
      .high_o(hs), .low_o(ls), .special_trigger_o(), .period_event_o(),
      .turn_event_o());
   mptb_gate_model #(.PAIRS(3)) load (.clk_i(clk_i), .rst_i(rst_i), .high_i(hi), .low_i(lo),
      .indep_i(indep), .fault_o(fault));
   function automatic logic [31:0] rnd();
      rs ^= rs << 13;
      rs ^= rs >> 17;
      rs ^= rs << 5;
      return rs;
   endfunction
   function automatic logic pick(input int s);
      return s == 0 ? pev : (s == 1 ? tev : trig);
   endfunction
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      tests_run++;
      if (g !== e) begin
         err_count++;
         $display("[ERR] %0t got %h want %h", $time, g, e);
      end
   endtask
   // one classic cycle; holds everything until ack is sampled high
   task automatic bus(input logic w, input logic [4:0] a, input logic [15:0] d);
      int k;
      k = 0;
      @(posedge clk_i);
      cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; sel <= 4'h3; wdat <= {16'h0000, d};
      do begin
         @(posedge clk_i);
         k++;
      end while (ack !== 1'b1 && k < 50);
      q = rdat[15:0];
      cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
      if (k >= 50) chk(16'hDEAD, 16'h0000);
   endtask
   // stop, clear the count, then load period and control
   task automatic cfg(input logic [15:0] pr, input logic [15:0] c);
      bus(1, 5'h00, 16'h0000);
      bus(1, 5'h04, 16'h0000);
      bus(1, 5'h08, pr);
      bus(1, 5'h00, c);
   endtask
   // cycles between two pulses of the chosen event output
   task automatic gap(input int s, input int e);
      n = 0;
      while (pick(s) !== 1'b1 && n < 9000) begin
         @(posedge clk_i);
         n++;
      end
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (pick(s) !== 1'b1 && n < 9000);
      chk(16'(n), 16'(e));
   endtask
   task automatic final_report();
      $display("mismatches %0d comparisons %0d", err_count, tests_run);
      if (err_count == 0 && tests_run > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      repeat (90000) @(posedge clk_i);
      err_count++;
      final_report();
   end
   initial begin
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      foreach (p[i]) if (i < 6) begin bus(0, 5'(i * 4 + (i > 4) * 8), 0); chk(q, 0); end
      bus(1, 5'h00, 16'h7FFF); bus(0, 5'h00, 0); chk(q, 16'h20FF);
      bus(1, 5'h08, 16'hFFFF); bus(0, 5'h08, 0); chk(q, 16'h7FFF);
      bus(1, 5'h04, 16'hFFFF); bus(0, 5'h04, 0); chk(q, 16'h7FFF);
      for (int i = 0; i < 3; i++) bus(1, 5'(16 + 4 * i), 16'(rnd() % 8));
      // every prescale code; postscale 15 for the first, random 0..3 for the others
      for (int k = 0; k < 4; k++) begin
         n = (k == 0) ? 15 : rnd() % 4;
         p = 16'(2 + rnd() % 8);
         indep <= 3'(rnd());
         cfg(p, {8'h80, 4'(n), 2'(k), 2'b00});
         gap(0, (p + 1) * (1 << 2 * k) * (n + 1));
      end
      cfg(p, 16'h8002); gap(0, 2 * p); gap(1, 2 * p);
      cfg(p, 16'h8003); gap(1, p);
      for (int d = 0; d < 2; d++) begin
         bus(1, 5'h0C, {1'(d), 15'(p / 2)});
         cfg(p, 16'h8002); gap(2, 2 * p);
      end
      cfg(p, 16'h8000); n = 0; // counting up only, so no downward match
      repeat (4 * p + 4) @(posedge clk_i) n += trig;
      chk(16'(n), 0);
      cfg(16'h0028, 16'h8002); gap(0, 80); repeat (50) @(posedge clk_i);
      bus(0, 5'h04, 0); chk(q & 16'h8000, 16'h8000);
      // one period of p + 1 ticks, the event registered one cycle later
      cfg(p, 16'h8001);
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (pev !== 1'b1 && n < 9000);
      chk(16'(n), 16'(p + 2));
      n = 0;
      repeat (4 * p + 4) @(posedge clk_i) n += pev;
      chk(16'(n), 0);
      bus(0, 5'h00, 0); chk(q, 16'h0001);
      bus(1, 5'h04, 16'h0009); repeat (10) @(posedge clk_i);
      bus(0, 5'h04, 0); chk(q, 16'h0009);
      // stopped count 9 against duties above, at zero and just above it
      indep <= 3'b000;
      bus(1, 5'h10, 16'h7FFF); bus(1, 5'h14, 16'h0000); bus(1, 5'h18, 16'h000A);
      repeat (2) @(posedge clk_i);
      chk({13'h0, hi}, 16'h0005);
      chk({13'h0, lo}, 16'h0002);
      chk({14'h0, hs, ls}, 16'h0002);
      bus(0, 5'h18, 0); chk(q, 16'h000A);
      cfg(16'h0064, 16'hA000); idle <= 1'b1; repeat (4) @(posedge clk_i);
      bus(0, 5'h04, 0); p = q; repeat (5) @(posedge clk_i);
      bus(0, 5'h04, 0); chk(q, p);
      bus(1, 5'h00, 16'h8000); bus(0, 5'h04, 0); p = q;
      bus(0, 5'h04, 0); chk(16'(q !== p), 16'h0001);
      bus(0, 5'h1C, 0); chk(q, 0);
      chk(16'(fault), 0);
      final_report();
   end
endmodule
`default_nettype wire
